/* File: hdl/dac_startup_config.sv */
// Serial-port register map and clock controls set up at converter start-up
`timescale 1ns/1ps
module dac_startup_config
   import dac_cfg_pkg::*;
#(
   parameter int unsigned LOCK_CYCLES = LOCK_DEFAULT_CYCLES
)
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe_n,
   output logic sdo_out,
   output logic sdo_oe_n,
   input wire logic ref_tick,
   input wire logic dac_tick,
   output logic pfd_tick,
   output logic adc_clk_tick,
   output logic converter_power_down,
   output logic clock_receiver_power_down,
   output logic phy_reset,
   output logic boot_loader_en,
   output logic pll_bypass,
   output logic [PUMP_W-1:0] pump_current_setting,
   output logic [FBDIV_W-1:0] feedback_divider,
   output logic pll_locked,
   output logic four_wire_mode,
   input wire logic sync_request_in,
   input wire logic sync_cmos_select,
   output logic link_sync_request_output,
   output logic sync_lvds_en,
   output logic sync_cmos_en
);
   // ----------------------------------------
   // Pin filtering: {cs_n, sclk, sdio}
   // ----------------------------------------
   logic [2:0] pin_s1, pin_s2, pin_s3, pin_f;
   logic sclk_d;
   logic sclk_rise, sclk_fall, cs_active, sdio_bit;

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pin_s1 <= PIN_IDLE;
         pin_s2 <= PIN_IDLE;
         pin_s3 <= PIN_IDLE;
         pin_f <= PIN_IDLE;
         sclk_d <= 1'b0;
      end
      else
      begin
         pin_s1 <= {spi_cs_n, spi_sclk, sdio_in};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         // A bit moves only when the last two stages agree
         pin_f <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));
         sclk_d <= pin_f[1];
      end
   end

   assign cs_active = ~pin_f[2];
   assign sclk_rise = cs_active & pin_f[1] & ~sclk_d;
   assign sclk_fall = cs_active & ~pin_f[1] & sclk_d;
   assign sdio_bit = pin_f[0];

   // ----------------------------------------
   // Serial transaction
   // ----------------------------------------
   spi_state_e state;
   logic [4:0] bit_cnt;
   logic [INSTR_BITS-1:0] instr;
   logic [DATA_BITS-1:0] wr_byte, rd_shift;
   logic wr_pulse, rd_op;
   logic [ADDR_W-1:0] wr_addr;
   logic [INSTR_BITS-1:0] next_instr;
   logic [7:0] regs [REG_COUNT];
   logic [7:0] rd_value;

   assign next_instr = {instr[INSTR_BITS-2:0], sdio_bit};

   function automatic logic [4:0] find_reg(input logic [ADDR_W-1:0] addr);
      logic [4:0] hit;
      hit = 5'h10;
      for (int i = 0; i < REG_COUNT; i++)
         if (REG_ADDR[i] == addr)
            hit = 5'(i);
      return hit;
   endfunction : find_reg

   always_comb
   begin
      logic [4:0] idx;
      idx = find_reg(next_instr[ADDR_W-1:0]);
      if (next_instr[ADDR_W-1:0] == ADDR_PLL_STATUS)
         rd_value = {7'h0, pll_locked};
      else if (!idx[4])
         rd_value = regs[idx[3:0]];
      else
         rd_value = 8'h00;
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state <= ST_INSTR;
         bit_cnt <= 5'h0;
         instr <= '0;
         wr_byte <= '0;
         rd_shift <= '0;
         rd_op <= 1'b0;
         wr_pulse <= 1'b0;
         wr_addr <= '0;
      end
      else
      begin
         wr_pulse <= 1'b0;
         if (!cs_active)
         begin
            // Chip select high aborts a partial transaction
            state <= ST_INSTR;
            bit_cnt <= 5'h0;
            rd_op <= 1'b0;
         end
         else if (sclk_rise)
         begin
            case (state)
               ST_INSTR:
               begin
                  instr <= next_instr;
                  if (bit_cnt == 5'(INSTR_BITS - 1))
                  begin
                     state <= ST_DATA;
                     bit_cnt <= 5'h0;
                     rd_op <= next_instr[INSTR_BITS-1];
                     rd_shift <= rd_value;
                  end
                  else
                     bit_cnt <= bit_cnt + 5'h1;
               end
               ST_DATA:
               begin
                  wr_byte <= {wr_byte[DATA_BITS-2:0], sdio_bit};
                  if (bit_cnt == 5'(DATA_BITS - 1))
                  begin
                     state <= ST_HOLD;
                     wr_pulse <= ~rd_op;
                     wr_addr <= instr[ADDR_W-1:0];
                  end
                  bit_cnt <= bit_cnt + 5'h1;
               end
               default:
                  state <= ST_HOLD;
            endcase
         end
         else if (sclk_fall && state == ST_DATA && bit_cnt != 5'h0)
            rd_shift <= {rd_shift[DATA_BITS-2:0], 1'b0};
      end
   end

   // Read data leaves on sdio in 3-wire mode, on sdo in 4-wire mode
   logic drive_rd;
   assign drive_rd = cs_active && rd_op && state == ST_DATA;
   assign sdio_out = rd_shift[DATA_BITS-1];
   assign sdo_out = rd_shift[DATA_BITS-1];
   assign sdio_oe_n = ~(drive_rd & ~four_wire_mode);
   assign sdo_oe_n = ~(drive_rd & four_wire_mode);

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   logic soft_reset;
   logic [4:0] wr_idx;
   assign wr_idx = find_reg(wr_addr);
   assign soft_reset = wr_pulse && wr_addr == REG_ADDR[IDX_PORT_CFG]
                       && (wr_byte & SOFT_RESET_MASK) != 8'h00;

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         regs <= REG_RESET;
      else if (soft_reset)
         // Reset bits clear themselves; the rest of the map returns to defaults
         regs <= REG_RESET;
      else if (wr_pulse && !wr_idx[4])
         regs[wr_idx[3:0]] <= wr_byte;
   end

   assign four_wire_mode = regs[IDX_PORT_CFG][FOUR_WIRE_BIT];
   assign converter_power_down = regs[IDX_CONV_PWR][PWR_DOWN_BIT];
   assign clock_receiver_power_down = regs[IDX_CLKRX_PWR][PWR_DOWN_BIT];
   assign phy_reset = ~regs[IDX_PHY_RST][0];
   assign boot_loader_en = regs[IDX_BOOT][0];
   assign pll_bypass = regs[IDX_BYPASS][BYPASS_BIT];
   assign pump_current_setting = regs[IDX_PUMP][PUMP_W-1:0];
   assign feedback_divider = regs[IDX_FBDIV][FBDIV_W-1:0];

   // ----------------------------------------
   // Lock model
   // ----------------------------------------
   logic vco_hold;
   logic [31:0] lock_cnt;

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         vco_hold <= 1'b0;
         lock_cnt <= '0;
         pll_locked <= 1'b0;
      end
      else
      begin
         if (wr_pulse && wr_addr == ADDR_VCO_RESET)
            vco_hold <= wr_byte[VCO_RESET_BIT];
         // An external clock leaves the PLL idle, so lock clears the cycle after bypass sets and stays low
         if (soft_reset || vco_hold || pll_bypass)
         begin
            lock_cnt <= '0;
            pll_locked <= 1'b0;
         end
         else if (!pll_locked)
         begin
            lock_cnt <= lock_cnt + 32'h1;
            pll_locked <= lock_cnt >= 32'(LOCK_CYCLES - 1);
         end
      end
   end

   // ----------------------------------------
   // Dividers
   // ----------------------------------------
   tick_div_if pfd_bus();
   tick_div_if adc_bus();

   assign pfd_bus.tick_in = ref_tick;
   assign pfd_bus.ratio_m1 = regs[IDX_PREDIV][PREDIV_LSB +: RATIO_W];
   assign pfd_tick = pfd_bus.tick_out;
   assign adc_bus.tick_in = dac_tick;
   assign adc_bus.ratio_m1 = regs[IDX_FBDIV][ADC_DIV_LSB +: RATIO_W];
   assign adc_clk_tick = adc_bus.tick_out;

   tick_divider u_pfd_div (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(pfd_bus));
   tick_divider u_adc_div (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(adc_bus));

   // ----------------------------------------
   // Link sync output
   // ----------------------------------------
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         link_sync_request_output <= 1'b0;
         sync_lvds_en <= 1'b1;
         sync_cmos_en <= 1'b0;
      end
      else
      begin
         // Any glitch here forces a resync of the link, so it is registered
         link_sync_request_output <= sync_request_in;
         sync_lvds_en <= ~sync_cmos_select;
         sync_cmos_en <= sync_cmos_select;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_bypass_write;
      wr_pulse && wr_addr == REG_ADDR[IDX_BYPASS] && !soft_reset;
   endsequence

   property p_bypass_select;
      @(posedge sys_clk) disable iff (sys_rst)
      s_bypass_write |=> (pll_bypass == $past(wr_byte[BYPASS_BIT]))
         ##1 !(pll_bypass && pll_locked);
   endproperty
   a_bypass_select: assert property (p_bypass_select)
      else $error("clock source select not applied");
   property p_bypass_no_lock;
      @(posedge sys_clk) disable iff (sys_rst)
      $rose(pll_bypass) |=> !pll_locked [*4];
   endproperty
   a_bypass_no_lock: assert property (p_bypass_no_lock)
      else $error("lock reported while bypassed");

   property p_prediv_default;
      @(posedge sys_clk) disable iff (sys_rst)
      soft_reset |=> (regs[IDX_PREDIV] == REG_RESET[IDX_PREDIV]) && pfd_bus.ratio_m1 == 2'h0;
   endproperty
   a_prediv_default: assert property (p_prediv_default)
      else $error("predivider not back at default after soft reset");

   property p_sync_follow;
      @(posedge sys_clk) disable iff (sys_rst)
      $changed(sync_request_in) |=> link_sync_request_output == $past(sync_request_in)
         && sync_lvds_en != sync_cmos_en;
   endproperty
   a_sync_follow: assert property (p_sync_follow)
      else $error("sync request output did not follow request");
endmodule : dac_startup_config

/* File: hdl/dac_cfg_pkg.sv */
// Constants and register map of the converter start-up configuration block
// How it works
// - Register pll_bypass_select: 0x00 uses internal PLL, 0x01 bypasses it.
// - Bits 7:6 of pll_feedback_and_adc_clock_divider divide the ADC clock output by field plus one.
// - pll_predivider bits 1:0 hold predivider minus one; bits 7:2 keep 0x06.
// - Phase detector runs at reference rate divided by predivider.
// - Sync output pair is LVDS or CMOS; asserted it requests comma characters.
package dac_cfg_pkg;
   localparam int REG_COUNT = 16;
   localparam int ADDR_W = 15;
   localparam int INSTR_BITS = 16;
   localparam int DATA_BITS = 8;

   localparam int IDX_PORT_CFG = 0;
   localparam int IDX_CONV_PWR = 1;
   localparam int IDX_CLKRX_PWR = 2;
   localparam int IDX_BYPASS = 3;
   localparam int IDX_PHY_RST = 4;
   localparam int IDX_BOOT = 5;
   localparam int IDX_AUX_A = 6;
   localparam int IDX_AUX_B = 7;
   localparam int IDX_PREDIV = 8;
   localparam int IDX_PUMP = 9;
   localparam int IDX_REQ_A = 10;
   localparam int IDX_REQ_B = 11;
   localparam int IDX_REQ_C = 12;
   localparam int IDX_FBDIV = 13;
   localparam int IDX_REQ_D = 14;
   localparam int IDX_REQ_E = 15;

   localparam logic [ADDR_W-1:0] REG_ADDR [REG_COUNT] = '{
      15'h000, 15'h090, 15'h091, 15'h095, 15'h206, 15'h705, 15'h790, 15'h791,
      15'h793, 15'h794, 15'h796, 15'h797, 15'h798, 15'h799, 15'h7a0, 15'h7a2};
   localparam logic [7:0] REG_RESET [REG_COUNT] = '{
      8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h18, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   localparam logic [ADDR_W-1:0] ADDR_VCO_RESET = 15'h792;
   localparam logic [ADDR_W-1:0] ADDR_PLL_STATUS = 15'h7b5;

   localparam logic [7:0] SOFT_RESET_MASK = 8'h81;
   localparam int FOUR_WIRE_BIT = 4;
   localparam int VCO_RESET_BIT = 1;
   localparam int BYPASS_BIT = 0;
   localparam int PWR_DOWN_BIT = 0;
   localparam int PREDIV_LSB = 0;
   localparam int ADC_DIV_LSB = 6;
   localparam int FBDIV_W = 6;
   localparam int PUMP_W = 6;
   localparam int RATIO_W = 2;
   localparam logic [2:0] PIN_IDLE = 3'h4;
   localparam int LOCK_DEFAULT_CYCLES = 1000;

   typedef enum logic [1:0] {ST_INSTR, ST_DATA, ST_HOLD} spi_state_e;
endpackage : dac_cfg_pkg

/* File: hdl/tick_div_if.sv */
// Bundle between the configuration block and a tick divider
`timescale 1ns/1ps
interface tick_div_if;
   logic tick_in;
   logic [1:0] ratio_m1;
   logic tick_out;
   modport ctrl (output tick_in, output ratio_m1, input tick_out);
   modport div (input tick_in, input ratio_m1, output tick_out);
endinterface : tick_div_if

/* File: hdl/tick_divider.sv */
// Divides a tick stream by a programmable ratio of one to four
`timescale 1ns/1ps
module tick_divider
   import dac_cfg_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   tick_div_if.div bus
);
   logic [1:0] cnt;
   logic [2:0] seen;
   logic [1:0] ratio_d;
   logic primed;

   // ----------------------------------------
   // Divider
   // ----------------------------------------
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cnt <= 2'h0;
         bus.tick_out <= 1'b0;
      end
      else
      begin
         // Ratio lowered mid-period wraps on the next input tick
         bus.tick_out <= bus.tick_in && (cnt >= bus.ratio_m1);
         if (bus.tick_in)
            cnt <= (cnt >= bus.ratio_m1) ? 2'h0 : cnt + 2'h1;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         seen <= 3'h0;
         ratio_d <= 2'h0;
         primed <= 1'b0;
      end
      else
      begin
         if (bus.tick_out)
            seen <= {2'h0, bus.tick_in};
         else
            seen <= seen + {2'h0, bus.tick_in};
         ratio_d <= bus.ratio_m1;
         if (bus.ratio_m1 != ratio_d)
            primed <= 1'b0;
         else if (bus.tick_out)
            primed <= 1'b1;
      end
   end

   property p_div_period;
      @(posedge sys_clk) disable iff (sys_rst)
      (bus.tick_out && primed && $stable(bus.ratio_m1)) |-> (seen == {1'b0, bus.ratio_m1} + 3'h1);
   endproperty
   a_div_period: assert property (p_div_period)
      else $error("divided tick period does not match ratio");
endmodule : tick_divider

/* File: dv/spi_host_model.sv */
// Serial host model that drives framed byte accesses into the configuration port
`timescale 1ns/1ps
module spi_host_model
   import dac_cfg_pkg::*;
#(
   parameter int HALF = 6
)
(
   input wire logic sys_clk,
   output logic spi_cs_n,
   output logic spi_sclk,
   output logic sdio_in,
   input wire logic sdio_out,
   input wire logic sdio_oe_n,
   input wire logic sdo_out,
   input wire logic sdo_oe_n,
   input wire logic four_wire_mode
);
   int oe_faults;

   initial
   begin
      spi_cs_n = 1'b1;
      spi_sclk = 1'b0;
      sdio_in = 1'b0;
      oe_faults = 0;
   end

   task automatic half_wait();
      repeat (HALF) @(posedge sys_clk);
      #1;
   endtask : half_wait

   // --------------------------------------------------
   // One whole frame per call; clock idles low between frames
   // --------------------------------------------------
   task automatic xfer(input logic rd, input logic [ADDR_W-1:0] addr,
      input logic [DATA_BITS-1:0] wdata, output logic [DATA_BITS-1:0] rdata);
      logic [INSTR_BITS+DATA_BITS-1:0] frame;
      frame = {rd, addr, wdata};
      rdata = '0;
      half_wait();
      spi_cs_n = 1'b0;
      for (int i = INSTR_BITS + DATA_BITS - 1; i >= 0; i--)
      begin
         // Released line toggles so a stale level is never mistaken for data
         sdio_in = (rd && i < DATA_BITS) ? ~sdio_in : frame[i];
         half_wait();
         spi_sclk = 1'b1;
         if (rd && i < DATA_BITS)
         begin
            rdata[i] = four_wire_mode ? sdo_out : sdio_out;
            // Exactly one read driver, the one of the current port mode
            if ({sdio_oe_n, sdo_oe_n} !== (four_wire_mode ? 2'b10 : 2'b01))
               oe_faults++;
         end
         else if ({sdio_oe_n, sdo_oe_n} !== 2'b11)
            oe_faults++;
         half_wait();
         spi_sclk = 1'b0;
      end
      half_wait();
      spi_cs_n = 1'b1;
      sdio_in = ~sdio_in;
      repeat (2) half_wait();
   endtask : xfer
endmodule : spi_host_model

/* File: dv/test_dac_startup_pll_config_sequence.sv */
// Self-checking testbench for the converter start-up configuration block
`timescale 1ns/1ps
module test_dac_startup_pll_config_sequence;
   import dac_cfg_pkg::*;
   localparam int LOCK_N = 20;
   logic sys_clk, sys_rst, spi_cs_n, spi_sclk, sdio_in, sdio_out, sdio_oe_n, sdo_out, sdo_oe_n;
   logic ref_tick, dac_tick, pfd_tick, adc_clk_tick, converter_power_down;
   logic clock_receiver_power_down, phy_reset, boot_loader_en, pll_bypass, pll_locked;
   logic four_wire_mode, sync_request_in, sync_cmos_select, link_sync_request_output;
   logic sync_lvds_en, sync_cmos_en, prev_req, prev_cmos;
   logic [PUMP_W-1:0] pump_current_setting;
   logic [FBDIV_W-1:0] feedback_divider;
   logic [7:0] rd_val, cp, fb;
   int errors, samples_checked, phase, ref_cnt, dac_cnt, pfd_last, adc_last, pfd_gap, adc_gap;
   int mreg [int];

   dac_startup_config #(.LOCK_CYCLES(LOCK_N)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .sdio_in(sdio_in), .sdio_out(sdio_out),
      .sdio_oe_n(sdio_oe_n), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .ref_tick(ref_tick),
      .dac_tick(dac_tick), .pfd_tick(pfd_tick), .adc_clk_tick(adc_clk_tick),
      .converter_power_down(converter_power_down),
      .clock_receiver_power_down(clock_receiver_power_down), .phy_reset(phy_reset),
      .boot_loader_en(boot_loader_en), .pll_bypass(pll_bypass),
      .pump_current_setting(pump_current_setting), .feedback_divider(feedback_divider),
      .pll_locked(pll_locked), .four_wire_mode(four_wire_mode),
      .sync_request_in(sync_request_in), .sync_cmos_select(sync_cmos_select),
      .link_sync_request_output(link_sync_request_output), .sync_lvds_en(sync_lvds_en),
      .sync_cmos_en(sync_cmos_en));

   spi_host_model host (.sys_clk(sys_clk), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
      .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .sdo_out(sdo_out),
      .sdo_oe_n(sdo_oe_n), .four_wire_mode(four_wire_mode));

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // --------------------------------------------------
   // Tick sources and divider period monitors
   // --------------------------------------------------
   always @(posedge sys_clk)
   begin
      #1;
      phase = (phase + 1) % 4;
      ref_tick = (phase == 0);
      dac_tick = (phase == 2);
   end

   // Falling edge sees settled ticks; an output tick answers the input counted before
   always @(negedge sys_clk)
   begin
      if (pfd_tick === 1'b1)
      begin
         pfd_gap = ref_cnt - pfd_last;
         pfd_last = ref_cnt;
      end
      if (adc_clk_tick === 1'b1)
      begin
         adc_gap = dac_cnt - adc_last;
         adc_last = dac_cnt;
      end
      if (ref_tick)
         ref_cnt++;
      if (dac_tick)
         dac_cnt++;
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check

   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report

   task automatic load_defaults();
      for (int i = 0; i < REG_COUNT; i++)
         mreg[int'(REG_ADDR[i])] = int'(REG_RESET[i]);
   endtask : load_defaults

   task automatic check_outs();
      check("converter_power_down", mreg['h090] & 1, 32'(converter_power_down));
      check("clock_receiver_power_down", mreg['h091] & 1,
         32'(clock_receiver_power_down));
      check("phy_reset", ~mreg['h206] & 1, 32'(phy_reset));
      check("boot_loader_en", mreg['h705] & 1, 32'(boot_loader_en));
      check("pll_bypass", mreg['h095] & 1, 32'(pll_bypass));
      check("four_wire_mode", (mreg['h000] >> 4) & 1, 32'(four_wire_mode));
      check("pump_current_setting", mreg['h794] & 'h3f, 32'(pump_current_setting));
      check("feedback_divider", mreg['h799] & 'h3f, 32'(feedback_divider));
   endtask : check_outs

   task automatic mw(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      logic [7:0] unused;
      host.xfer(1'b0, a, d, unused);
      if (a == 15'h000 && (d & SOFT_RESET_MASK) != 8'h00)
         load_defaults();
      else if (mreg.exists(int'(a)))
         mreg[int'(a)] = int'(d);
      check_outs();
   endtask : mw

   initial
   begin
      repeat (100000) @(posedge sys_clk);
      errors++;
      final_report();
   end

   initial
   begin
      {ref_tick, dac_tick, sync_request_in, sync_cmos_select} = 4'h0;
      {errors, samples_checked, phase, ref_cnt, dac_cnt, pfd_last, adc_last} = '0;
      sys_rst = 1'b1;
      load_defaults();
      rd_val = 8'($urandom(32'h0af8));
      repeat (6) @(posedge sys_clk);
      #1 sys_rst = 1'b0;
      check_outs();
      host.xfer(1'b1, 15'h0c0, 8'h00, rd_val);
      check("unmapped read", 32'h0, 32'(rd_val));
      mw(15'h000, 8'h81);
      mw(15'h000, 8'h3c);
      mw(15'h091, 8'h00);
      mw(15'h206, 8'h01);
      mw(15'h705, 8'h01);
      mw(15'h090, 8'h00);
      // ------------------ PLL path ------------------
      mw(15'h095, 8'h00);
      mw(15'h790, 8'h00);
      mw(15'h791, 8'h00);
      mw(15'h796, 8'he5);
      mw(15'h7a0, 8'hbc);
      cp = 8'(4 + $urandom % 13);
      mw(15'h794, cp);
      mw(15'h797, 8'h10);
      mw(15'h797, 8'h20);
      mw(15'h798, 8'h10);
      mw(15'h7a2, 8'h7f);
      // Pause scaled down; nothing in the block times it
      repeat (100) @(posedge sys_clk);
      for (int k = 0; k < 4; k++)
      begin
         fb = 8'($urandom % 64);
         mw(15'h799, {2'(k), fb[5:0]});
         mw(15'h793, {6'h06, 2'(3 - k)});
         repeat (120) @(posedge sys_clk);
         #1;
         check("pfd ratio", 32'(4 - k), 32'(pfd_gap));
         check("adc clock ratio", 32'(k + 1), 32'(adc_gap));
      end
      mw(ADDR_VCO_RESET, 8'h02);
      check("pll_locked held", 32'h0, 32'(pll_locked));
      mw(ADDR_VCO_RESET, 8'h00);
      check("pll_locked early", 32'h0, 32'(pll_locked));
      repeat (LOCK_N) @(posedge sys_clk);
      #1;
      check("pll_locked", 32'h1, 32'(pll_locked));
      host.xfer(1'b1, ADDR_PLL_STATUS, 8'h00, rd_val);
      check("lock status bit", 32'h1, 32'(rd_val[0]));
      // ------------------ Bypass path ------------------
      mw(15'h000, 8'h81);
      mw(15'h095, 8'h01);
      mw(15'h790, 8'hff);
      mw(15'h791, 8'h1f);
      check("pll_locked bypass", 32'h0, 32'(pll_locked));
      // Back in 3-wire mode: a non-zero readback proves the shared data line
      host.xfer(1'b1, 15'h791, 8'h00, rd_val);
      check("bypass readback", 32'(mreg['h791]), 32'(rd_val));
      check("read driver enable faults", 32'h0, 32'(host.oe_faults));
      // ------------------ Sync output ------------------
      for (int i = 0; i < 40; i++)
      begin
         @(posedge sys_clk);
         #1;
         if (i > 0)
         begin
            check("link_sync_request_output", 32'(prev_req),
               32'(link_sync_request_output));
            check("sync_cmos_en", 32'(prev_cmos), 32'(sync_cmos_en));
            check("sync_lvds_en", 32'(!prev_cmos), 32'(sync_lvds_en));
         end
         prev_req = 1'($urandom);
         prev_cmos = 1'($urandom);
         sync_request_in = prev_req;
         sync_cmos_select = prev_cmos;
      end
      final_report();
   end
endmodule : test_dac_startup_pll_config_sequence
